// ---- core/brctl_cond.sv ----
`default_nettype none
module brctl_cond (
    brctl_cond_if.eval c
);
    always_comb begin
        c.is_jump = 1'b1;
        c.take    = 1'b0;
        unique case (c.opcode)
            brctl_pkg::OP_JMP_T0_LOW:  c.take = c.t0_low;
            brctl_pkg::OP_JMP_T1_LOW:  c.take = c.t1_low;
            brctl_pkg::OP_JMP_NZ:      c.take = ~c.acc_zero;
            brctl_pkg::OP_JMP_TF:      c.take = c.tf_set;
            brctl_pkg::OP_JMP_T0_HIGH: c.take = ~c.t0_low;
            brctl_pkg::OP_JMP_T1_HIGH: c.take = ~c.t1_low;
            brctl_pkg::OP_JMP_ZERO:    c.take = c.acc_zero;
            default:                   c.is_jump = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// ---- core/brctl_cond_if.sv ----
`default_nettype none
interface brctl_cond_if;
    logic [7:0] opcode;
    logic       t0_low;
    logic       t1_low;
    logic       acc_zero;
    logic       tf_set;
    logic       is_jump;
    logic       take;
    modport user (output opcode, t0_low, t1_low, acc_zero, tf_set,
                  input is_jump, take);
    modport eval (input opcode, t0_low, t1_low, acc_zero, tf_set,
                  output is_jump, take);
endinterface
`default_nettype wire

// ---- core/brctl_pkg.sv ----
`default_nettype none
package brctl_pkg;
    localparam logic [7:0] OP_JMP_T0_LOW   = 8'h26;
    localparam logic [7:0] OP_JMP_T1_LOW   = 8'h46;
    localparam logic [7:0] OP_JMP_NZ       = 8'h96;
    localparam logic [7:0] OP_JMP_TF       = 8'h16;
    localparam logic [7:0] OP_JMP_T0_HIGH  = 8'h36;
    localparam logic [7:0] OP_JMP_T1_HIGH  = 8'h56;
    localparam logic [7:0] OP_JMP_ZERO     = 8'hC6;
    localparam logic [7:0] OP_IRQ_ENABLE   = 8'h05;
    localparam logic [7:0] OP_IRQ_DISABLE  = 8'h15;
    localparam logic [7:0] OP_T0_CLK_OUT   = 8'h75;
    localparam logic [7:0] OP_PBANK_LOW    = 8'hE5;
    localparam logic [7:0] OP_PBANK_HIGH   = 8'hF5;
    localparam logic [7:0] OP_RBANK_LOW    = 8'hC5;
    localparam logic [7:0] OP_RBANK_HIGH   = 8'hD5;
    localparam logic [11:0] PC_RESET       = 12'h000;
    localparam logic [11:0] PC_STEP_ONE    = 12'h001;
    localparam int          PC_LOW_W       = 8;
    localparam int          PC_W           = 12;
    typedef enum logic [1:0] {
        BRCTL_ST_OPCODE  = 2'b01,
        BRCTL_ST_ADDRESS = 2'b10
    } brctl_state_type;
endpackage
`default_nettype wire

// ---- core/brctl_top.sv ----
// Overview of operation
// - opcode 26h jumps in page when test zero is low, else pc plus two.
// - opcode 46h jumps in page when test one is low, else pc plus two.
// - opcode 96h jumps in page when the accumulator is nonzero.
// - opcode 16h jumps in page when the timer flag is one.
// - opcodes 36h and 56h jump when test zero or one is high.
// - opcode C6h jumps in page when the accumulator is zero.
// - opcode 05h sets the external interrupt enable.
// - opcode 15h clears the external interrupt enable.
// - opcode 75h turns test pin zero into a clock output.
// - opcode E5h clears the program bank flag (low bank).
// - opcode F5h sets the program bank flag (high bank).
// - opcode C5h clears the register bank bit (locations 0-7).
// - opcode D5h sets the register bank bit (locations 24-31).
// - interrupts start only when enabled, and reset clears the enable.
// - with clock out on, test pin zero shows the state clock.
`default_nettype none
module brctl_top (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  instr_byte,
    input  wire logic        instr_valid,
    input  wire logic        test_input_zero,
    input  wire logic        test_input_one,
    input  wire logic        timer_overflow_flag,
    input  wire logic [7:0]  acc,
    input  wire logic        ext_irq_n,
    input  wire logic        state_clk,
    output logic [11:0]      pc,
    output logic             irq_enable,
    output logic             irq_request,
    output logic             t0_clk_enable,
    output logic             t0_out,
    output logic             t0_oe,
    output logic             program_bank_flag,
    output logic             register_bank_bit,
    output logic             jump_taken
);
    // pins pass two flops before use
    logic [1:0] t0_s_r, t1_s_r, tf_s_r, irq_s_r, sclk_s_r;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            t0_s_r   <= 2'h0;
            t1_s_r   <= 2'h0;
            tf_s_r   <= 2'h0;
            irq_s_r  <= 2'h3;
            sclk_s_r <= 2'h0;
        end else begin
            t0_s_r   <= {t0_s_r[0], test_input_zero};
            t1_s_r   <= {t1_s_r[0], test_input_one};
            tf_s_r   <= {tf_s_r[0], timer_overflow_flag};
            irq_s_r  <= {irq_s_r[0], ext_irq_n};
            sclk_s_r <= {sclk_s_r[0], state_clk};
        end
    end

    brctl_cond_if cif ();
    brctl_cond u_cond (
        .c (cif)
    );

    brctl_pkg::brctl_state_type state_r, state_nxt;
    logic [7:0]  op_r, op_nxt;
    logic [11:0] pc_r, pc_nxt;
    logic        ie_r, ie_nxt, ck_r, ck_nxt;
    logic        pb_r, pb_nxt, rb_r, rb_nxt;
    logic        jt_r, jt_nxt, irq_r, irq_nxt, t0o_r, t0o_nxt;

    // jump decode on the fresh byte, condition on the held opcode
    assign cif.opcode   = (state_r == brctl_pkg::BRCTL_ST_OPCODE) ?
                          instr_byte : op_r;
    assign cif.t0_low   = ~t0_s_r[1];
    assign cif.t1_low   = ~t1_s_r[1];
    assign cif.acc_zero = (acc == 8'h00);
    assign cif.tf_set   = tf_s_r[1];

    function automatic logic [11:0] pc_inc(input logic [11:0] p);
        pc_inc = p + brctl_pkg::PC_STEP_ONE;
    endfunction

    always_comb begin
        state_nxt = state_r;
        op_nxt    = op_r;
        pc_nxt    = pc_r;
        ie_nxt    = ie_r;
        ck_nxt    = ck_r;
        pb_nxt    = pb_r;
        rb_nxt    = rb_r;
        jt_nxt    = 1'b0;
        unique case (state_r)
            brctl_pkg::BRCTL_ST_OPCODE: if (instr_valid) begin
                op_nxt = instr_byte;
                pc_nxt = pc_inc(pc_r);
                unique case (instr_byte)
                    brctl_pkg::OP_IRQ_ENABLE:  ie_nxt = 1'b1;
                    brctl_pkg::OP_IRQ_DISABLE: ie_nxt = 1'b0;
                    brctl_pkg::OP_T0_CLK_OUT:  ck_nxt = 1'b1;
                    brctl_pkg::OP_PBANK_LOW:   pb_nxt = 1'b0;
                    brctl_pkg::OP_PBANK_HIGH:  pb_nxt = 1'b1;
                    brctl_pkg::OP_RBANK_LOW:   rb_nxt = 1'b0;
                    brctl_pkg::OP_RBANK_HIGH:  rb_nxt = 1'b1;
                    default: ;
                endcase
                if (cif.is_jump)
                    state_nxt = brctl_pkg::BRCTL_ST_ADDRESS;
            end
            brctl_pkg::BRCTL_ST_ADDRESS: if (instr_valid) begin
                state_nxt = brctl_pkg::BRCTL_ST_OPCODE;
                // in-page target or skip by two
                if (cif.take) begin
                    pc_nxt = {pc_r[11:8], instr_byte};
                    jt_nxt = 1'b1;
                end else begin
                    pc_nxt = pc_inc(pc_r);
                end
            end
            default: state_nxt = brctl_pkg::BRCTL_ST_OPCODE;
        endcase
        irq_nxt = ie_nxt & ~irq_s_r[1];
        t0o_nxt = ck_nxt & sclk_s_r[1];
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_r <= brctl_pkg::BRCTL_ST_OPCODE;
            op_r    <= 8'h00;
            pc_r    <= brctl_pkg::PC_RESET;
            ie_r    <= 1'b0;
            ck_r    <= 1'b0;
            pb_r    <= 1'b0;
            rb_r    <= 1'b0;
            jt_r    <= 1'b0;
            irq_r   <= 1'b0;
            t0o_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            op_r    <= op_nxt;
            pc_r    <= pc_nxt;
            ie_r    <= ie_nxt;
            ck_r    <= ck_nxt;
            pb_r    <= pb_nxt;
            rb_r    <= rb_nxt;
            jt_r    <= jt_nxt;
            irq_r   <= irq_nxt;
            t0o_r   <= t0o_nxt;
        end
    end

    assign pc                = pc_r;
    assign irq_enable        = ie_r;
    assign irq_request       = irq_r;
    assign t0_clk_enable     = ck_r;
    assign t0_out            = t0o_r;
    assign t0_oe             = ck_r;
    assign program_bank_flag = pb_r;
    assign register_bank_bit = rb_r;
    assign jump_taken        = jt_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_jump_target: assert property (
        state_r == brctl_pkg::BRCTL_ST_ADDRESS && instr_valid && cif.take
        |=> pc_r == {$past(pc_r[11:8]), $past(instr_byte)} && jump_taken)
        else $error("jump target wrong");
    a_skip_two: assert property (
        state_r == brctl_pkg::BRCTL_ST_OPCODE && instr_valid && cif.is_jump
        ##1 instr_valid && !cif.take |=> pc_r == $past(pc_r, 2) + 12'h002)
        else $error("skip not by two");
    a_irq_enable_set: assert property (
        state_r == brctl_pkg::BRCTL_ST_OPCODE && instr_valid
        && instr_byte == brctl_pkg::OP_IRQ_ENABLE |=> irq_enable)
        else $error("enable not set");
    a_irq_enable_clr: assert property (
        state_r == brctl_pkg::BRCTL_ST_OPCODE && instr_valid
        && instr_byte == brctl_pkg::OP_IRQ_DISABLE |=> !irq_enable)
        else $error("enable not cleared");
    a_irq_gated: assert property (
        !irq_enable |-> !irq_request)
        else $error("irq without enable");
    a_clk_out_on: assert property (
        state_r == brctl_pkg::BRCTL_ST_OPCODE && instr_valid
        && instr_byte == brctl_pkg::OP_T0_CLK_OUT |=> t0_oe ##1 t0_oe)
        else $error("clock out not on");
    a_pbank_high: assert property (
        state_r == brctl_pkg::BRCTL_ST_OPCODE && instr_valid
        && instr_byte == brctl_pkg::OP_PBANK_HIGH |=> program_bank_flag)
        else $error("program bank not high");
    a_rbank_high: assert property (
        state_r == brctl_pkg::BRCTL_ST_OPCODE && instr_valid
        && instr_byte == brctl_pkg::OP_RBANK_HIGH |=> register_bank_bit)
        else $error("register bank not high");
    a_pbank_low: assert property (
        state_r == brctl_pkg::BRCTL_ST_OPCODE && instr_valid
        && instr_byte == brctl_pkg::OP_PBANK_LOW |=> !program_bank_flag)
        else $error("program bank not low");
    a_rbank_low: assert property (
        state_r == brctl_pkg::BRCTL_ST_OPCODE && instr_valid
        && instr_byte == brctl_pkg::OP_RBANK_LOW |=> !register_bank_bit)
        else $error("register bank not low");
    a_reset_clears: assert property (
        disable iff (1'b0) !resetn |=> !irq_enable && !irq_request)
        else $error("reset left enable set");
    a_tf_jump: assert property (
        state_r == brctl_pkg::BRCTL_ST_ADDRESS && instr_valid
        && op_r == brctl_pkg::OP_JMP_TF && tf_s_r[1] |=> jump_taken)
        else $error("timer jump missed");

    c_jump: cover property (jump_taken);
    c_irq: cover property (irq_request);
    c_clk: cover property (t0_out);
    c_bank: cover property (program_bank_flag && register_bank_bit);
endmodule
`default_nettype wire

// ---- sim/brctl_prog_mem.sv ----
`default_nettype none
module brctl_prog_mem (
    input  wire logic       clk,
    input  wire logic       send,
    input  wire logic [7:0] byte_in,
    output logic      [7:0] instr_byte,
    output logic            instr_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] last_r = 8'hA5;
    always @(posedge clk) begin
        if (send) begin
            last_r <= byte_in;
        end
    end
    // idle bus shows the inverse, so a stale byte never looks valid
    assign instr_valid = send;
    assign instr_byte  = send ? byte_in : ~last_r;
endmodule
`default_nettype wire

// ---- sim/tb_branch_control_opcode_decoder.sv ----
`default_nettype none
module tb_branch_control_opcode_decoder;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, resetn, send, t0, t1, tf, irq_n, sclk;
    logic [7:0]  byte_in, instr_byte, acc, exp_f;
    logic        instr_valid, irq_en, irq_req, t0_en, t0_out, t0_oe;
    logic        pbank, rbank, jt;
    logic [11:0] pc, exp_pc;
    logic [31:0] rnd;
    int          err_count, compares;
    logic [7:0]  jops [7] = '{brctl_pkg::OP_JMP_T0_LOW,
        brctl_pkg::OP_JMP_T1_LOW, brctl_pkg::OP_JMP_NZ, brctl_pkg::OP_JMP_TF,
        brctl_pkg::OP_JMP_T0_HIGH, brctl_pkg::OP_JMP_T1_HIGH,
        brctl_pkg::OP_JMP_ZERO};
    wire logic [19:0] obs = {pc, irq_en, irq_req, t0_en, t0_oe, t0_out,
                             pbank, rbank, jt};

    brctl_prog_mem mem (.clk(clk), .send(send), .byte_in(byte_in),
        .instr_byte(instr_byte), .instr_valid(instr_valid));
    brctl_top uut (.clk(clk), .resetn(resetn), .instr_byte(instr_byte),
        .instr_valid(instr_valid), .test_input_zero(t0),
        .test_input_one(t1), .timer_overflow_flag(tf), .acc(acc),
        .ext_irq_n(irq_n), .state_clk(sclk), .pc(pc), .irq_enable(irq_en),
        .irq_request(irq_req), .t0_clk_enable(t0_en), .t0_out(t0_out),
        .t0_oe(t0_oe), .program_bank_flag(pbank),
        .register_bank_bit(rbank), .jump_taken(jt));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic taken(input logic [7:0] op);
        case (op)
            brctl_pkg::OP_JMP_T0_LOW:  return !t0;
            brctl_pkg::OP_JMP_T1_LOW:  return !t1;
            brctl_pkg::OP_JMP_NZ:      return acc != 8'h00;
            brctl_pkg::OP_JMP_TF:      return tf;
            brctl_pkg::OP_JMP_T0_HIGH: return t0;
            brctl_pkg::OP_JMP_T1_HIGH: return t1;
            default:                   return acc == 8'h00;
        endcase
    endfunction
    task automatic chk;
        compares++;
        if (obs !== {exp_pc, exp_f}) begin
            $display("wrong value at %0t: got %h expected %h", $time, obs,
                     {exp_pc, exp_f});
            err_count++;
        end
    endtask
    // settle n edges, compare 1 ns after the edge, end on an edge
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
        chk();
        @(posedge clk);
    endtask
    task automatic issue(input logic [7:0] b);
        send    <= 1'b1;
        byte_in <= b;
        @(posedge clk);
    endtask
    task automatic op1(input logic [7:0] b, input logic [7:0] f);
        issue(b);
        send <= 1'b0;
        exp_pc = exp_pc + 12'h001;
        exp_f  = f;
        settle(0);
    endtask
    task automatic jump(input logic [7:0] op, input logic [7:0] a);
        logic [11:0] p1;
        p1 = exp_pc + 12'h001;
        exp_f[0] = taken(op);
        issue(op);
        issue(a);
        send <= 1'b0;
        exp_pc = exp_f[0] ? {p1[11:8], a} : p1 + 12'h001;
        settle(0);
        exp_f[0] = 1'b0;
        settle(0);
    endtask
    task automatic test_done;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        resetn = 1'b0; send = 1'b0; byte_in = 8'h00; acc = 8'h00;
        t0 = 1'b1; t1 = 1'b1; tf = 1'b0; irq_n = 1'b1; sclk = 1'b0;
        rnd = 32'h7e19; exp_pc = 12'h000; exp_f = 8'h00;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        settle(0);
        op1(brctl_pkg::OP_IRQ_ENABLE, 8'h80);
        irq_n <= 1'b0;
        exp_f = 8'hC0;
        settle(4);
        op1(brctl_pkg::OP_IRQ_DISABLE, 8'h00);
        irq_n <= 1'b1;
        op1(brctl_pkg::OP_T0_CLK_OUT, 8'h30);
        sclk <= 1'b1;
        exp_f = 8'h38;
        settle(4);
        sclk <= 1'b0;
        exp_f = 8'h30;
        settle(4);
        op1(brctl_pkg::OP_PBANK_HIGH, 8'h34);
        op1(brctl_pkg::OP_RBANK_HIGH, 8'h36);
        // walk to the page end so the jump lands in the next page
        repeat (8'hFF - exp_pc[7:0]) op1(8'h00, 8'h36);
        t0 <= 1'b0;
        repeat (4) @(posedge clk);
        jump(brctl_pkg::OP_JMP_T0_LOW, 8'h5A);
        for (int i = 0; i < 42; i++) begin
            rnd = lfsr(rnd);
            t0  <= rnd[0];
            t1  <= rnd[1];
            tf  <= rnd[2];
            acc <= rnd[3] ? rnd[15:8] : 8'h00;
            repeat (4) @(posedge clk);
            jump(jops[i % 7], rnd[31:24]);
        end
        op1(brctl_pkg::OP_PBANK_LOW, 8'h32);
        op1(brctl_pkg::OP_RBANK_LOW, 8'h30);
        op1(8'h00, 8'h30);
        op1(brctl_pkg::OP_IRQ_ENABLE, 8'hB0);
        resetn <= 1'b0;
        @(posedge clk);
        resetn <= 1'b1;
        exp_pc = 12'h000;
        exp_f  = 8'h00;
        settle(0);
        test_done();
    end
endmodule
`default_nettype wire
